// File: core/bcsc_core.v
`timescale 1ns/1ps
`include "bcsc_defines.vh"

// How it works
// - page branch via d/e: pc[7:4]=d, pc[3:0]=e, upper bits kept
// - page branch via x/a: pc[7:4]=x, pc[3:0]=a, upper bits kept
// - opcode at page offsets fe/ff uses next page's upper bits
// - full branch via b,c,d,e loads pc from c,d,e; b should be zero
// - full branch via b,c,x,a loads pc from c,x,a; b should be zero
// - four-nibble call frame: pc7-4, pc3-0, flags, pc11-8, sp minus 4
// - six-nibble call frame: sp-1 left unwritten, then flags, pc7-4, pc3-0, zero, pc11-8 from sp-2 down, sp minus 6
// - short call pushes same frame, loads 11-bit target zero-extended
// - return restores pc from sp, sp+2, sp+3; flags and sp step by mode
// - return-and-skip restores like return then skips next instruction
// - return and return-and-skip restore only the two bank-enable flags
// - interrupt return restores pc, status low/high from sp+4/sp+5, sp plus 6
// - push pair writes high nibble to sp-1, low to sp-2, sp minus 2
// - push bank selects: memory select to sp-1, register select to sp-2
// - pop pair: low from sp, high from sp+1, sp plus 2
// - pop bank selects: register select from sp, memory select from sp+1
// - global enable sets master enable, bit 3 of priority select
// - interrupt accepted only with master and source enable set
// - global disable clears master enable
// - source enable sets the chosen source enable flag
// - source disable clears the chosen source enable flag
module bcsc_core (
    // clock and reset
    input wire mclk,
    input wire rst_n,
    // instruction request
    input wire op_valid,
    input wire [4:0] op_code,
    input wire [11:0] op_pc,
    input wire [11:0] op_target,
    input wire [1:0] op_pair,
    input wire [2:0] op_src,
    input wire six_nibble_frame_mode,
    // register file view
    input wire [3:0] reg_a,
    input wire [3:0] reg_x,
    input wire [3:0] reg_b,
    input wire [3:0] reg_c,
    input wire [3:0] reg_d,
    input wire [3:0] reg_e,
    input wire [3:0] reg_h,
    input wire [3:0] reg_l,
    input wire [3:0] memory_bank_select,
    input wire [1:0] register_bank_select,
    input wire [7:0] program_status_word,
    // interrupt requests
    input wire [6:0] irq_req,
    // stack memory
    output reg stk_we_ff,
    output reg [7:0] stk_addr_ff,
    output reg [3:0] stk_wdata_ff,
    input wire [3:0] stk_rdata,
    // results
    output reg busy_ff,
    output reg done_ff,
    output reg pc_load_ff,
    output reg [11:0] pc_ff,
    output reg skip_ff,
    output reg [7:0] stack_pointer_ff,
    output reg reg_load_ff,
    output reg [1:0] reg_pair_ff,
    output reg [3:0] reg_hi_ff,
    output reg [3:0] reg_lo_ff,
    output reg bs_load_ff,
    output reg [3:0] mbs_ff,
    output reg [1:0] rbs_ff,
    output reg psw_load_ff,
    output reg [7:0] psw_ff,
    output reg master_interrupt_enable_ff,
    output reg [6:0] source_interrupt_enable_ff,
    output reg [6:0] irq_accept_ff
);

// ****************************************
// state
// ****************************************
localparam ST_IDLE = 2'h0;
localparam ST_WR = 2'h1;
localparam ST_RD = 2'h2;
localparam ST_FIN = 2'h3;

reg [1:0] st_ff;
reg [4:0] op_ff;
reg [2:0] idx_ff;
reg [2:0] cnt_ff;
reg [11:0] tgt_ff;
reg [3:0] nib_ff [0:5];
reg [3:0] rd_ff [0:5];
reg rd_pend_ff;
reg [2:0] rd_idx_ff;
reg [1:0] pair_ff;
reg six_ff;

wire [11:0] ret_pc = op_pc;
wire [3:0] page_hi = (op_pc[7:0] >= `BCSC_PAGE_LAST) ? (op_pc[11:8] + 4'h1) : op_pc[11:8];
wire [1:0] flags = program_status_word[7:6];
wire [3:0] sel_hi = (op_pair == `BCSC_RP_XA) ? reg_x : (op_pair == `BCSC_RP_HL) ? reg_h :
                    (op_pair == `BCSC_RP_DE) ? reg_d : reg_b;
wire [3:0] sel_lo = (op_pair == `BCSC_RP_XA) ? reg_a : (op_pair == `BCSC_RP_HL) ? reg_l :
                    (op_pair == `BCSC_RP_DE) ? reg_e : reg_c;
wire is_call = (op_code == `BCSC_OP_WIDE_ABSOLUTE_CALL) || (op_code == `BCSC_OP_SHORT_FIXED_CALL);
wire is_ret = (op_code == `BCSC_OP_RET) || (op_code == `BCSC_OP_RETURN_AND_SKIP) || (op_code == `BCSC_OP_INTERRUPT_RETURN);
wire [2:0] ret_len = ((op_code == `BCSC_OP_INTERRUPT_RETURN) || six_nibble_frame_mode) ? 3'h6 : 3'h4;

// irq synchronisers
reg [6:0] irq_s1_ff;
reg [6:0] irq_s2_ff;

// ****************************************
// sequencer
// ****************************************
integer i;
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        st_ff <= ST_IDLE;
        op_ff <= `BCSC_OP_NOP;
        idx_ff <= 3'h0;
        cnt_ff <= 3'h0;
        tgt_ff <= `BCSC_PC_RST;
        rd_pend_ff <= 1'b0;
        rd_idx_ff <= 3'h0;
        pair_ff <= 2'h0;
        six_ff <= 1'b0;
        for (i = 0; i < 6; i = i + 1) begin
            nib_ff[i] <= 4'h0;
            rd_ff[i] <= 4'h0;
        end
        stk_we_ff <= 1'b0;
        stk_addr_ff <= 8'h00;
        stk_wdata_ff <= 4'h0;
        busy_ff <= 1'b0;
        done_ff <= 1'b0;
        pc_load_ff <= 1'b0;
        pc_ff <= `BCSC_PC_RST;
        skip_ff <= 1'b0;
        stack_pointer_ff <= `BCSC_SP_RST;
        reg_load_ff <= 1'b0;
        reg_pair_ff <= 2'h0;
        reg_hi_ff <= 4'h0;
        reg_lo_ff <= 4'h0;
        bs_load_ff <= 1'b0;
        mbs_ff <= 4'h0;
        rbs_ff <= 2'h0;
        psw_load_ff <= 1'b0;
        psw_ff <= 8'h00;
        master_interrupt_enable_ff <= 1'b0;
        source_interrupt_enable_ff <= 7'h00;
    end else begin
        done_ff <= 1'b0;
        pc_load_ff <= 1'b0;
        skip_ff <= 1'b0;
        reg_load_ff <= 1'b0;
        bs_load_ff <= 1'b0;
        psw_load_ff <= 1'b0;
        stk_we_ff <= 1'b0;
        rd_pend_ff <= 1'b0;
        if (rd_pend_ff) begin
            rd_ff[rd_idx_ff] <= stk_rdata;
        end
        case (st_ff)
            ST_IDLE: begin
                if (op_valid) begin
                    op_ff <= op_code;
                    pair_ff <= op_pair;
                    six_ff <= six_nibble_frame_mode;
                    idx_ff <= 3'h0;
                    case (op_code)
                        `BCSC_OP_PAGE_DE: begin
                            pc_ff <= {page_hi, reg_d, reg_e};
                            pc_load_ff <= 1'b1;
                            done_ff <= 1'b1;
                        end
                        `BCSC_OP_PAGE_XA: begin
                            pc_ff <= {page_hi, reg_x, reg_a};
                            pc_load_ff <= 1'b1;
                            done_ff <= 1'b1;
                        end
                        `BCSC_OP_FULL_D: begin
                            pc_ff <= {reg_c, reg_d, reg_e};
                            pc_load_ff <= 1'b1;
                            done_ff <= 1'b1;
                        end
                        `BCSC_OP_FULL_X: begin
                            pc_ff <= {reg_c, reg_x, reg_a};
                            pc_load_ff <= 1'b1;
                            done_ff <= 1'b1;
                        end
                        `BCSC_OP_EI: begin
                            master_interrupt_enable_ff <= 1'b1;
                            done_ff <= 1'b1;
                        end
                        `BCSC_OP_DI: begin
                            master_interrupt_enable_ff <= 1'b0;
                            done_ff <= 1'b1;
                        end
                        `BCSC_OP_EI_SRC: begin
                            if (op_src < `BCSC_NSRC)
                                source_interrupt_enable_ff[op_src] <= 1'b1;
                            done_ff <= 1'b1;
                        end
                        `BCSC_OP_DI_SRC: begin
                            if (op_src < `BCSC_NSRC)
                                source_interrupt_enable_ff[op_src] <= 1'b0;
                            done_ff <= 1'b1;
                        end
                        `BCSC_OP_PUSH, `BCSC_OP_PUSH_BS: begin
                            // writes descend from sp-1
                            nib_ff[0] <= (op_code == `BCSC_OP_PUSH) ? sel_hi : memory_bank_select;
                            nib_ff[1] <= (op_code == `BCSC_OP_PUSH) ? sel_lo : {2'h0, register_bank_select};
                            cnt_ff <= 3'h2;
                            busy_ff <= 1'b1;
                            st_ff <= ST_WR;
                        end
                        `BCSC_OP_POP, `BCSC_OP_POP_BS: begin
                            cnt_ff <= 3'h2;
                            busy_ff <= 1'b1;
                            st_ff <= ST_RD;
                        end
                        default: begin
                            if (is_call) begin
                                tgt_ff <= (op_code == `BCSC_OP_SHORT_FIXED_CALL) ? (op_target & `BCSC_FAR_MASK) : op_target;
                                if (six_nibble_frame_mode) begin
                                    nib_ff[0] <= {2'h0, flags};
                                    nib_ff[1] <= ret_pc[7:4];
                                    nib_ff[2] <= ret_pc[3:0];
                                    nib_ff[3] <= 4'h0;
                                    nib_ff[4] <= ret_pc[11:8];
                                    cnt_ff <= 3'h5;
                                    idx_ff <= 3'h1;
                                end else begin
                                    nib_ff[0] <= ret_pc[7:4];
                                    nib_ff[1] <= ret_pc[3:0];
                                    nib_ff[2] <= {flags, 2'h0};
                                    nib_ff[3] <= ret_pc[11:8];
                                    cnt_ff <= 3'h4;
                                end
                                busy_ff <= 1'b1;
                                st_ff <= ST_WR;
                            end else if (is_ret) begin
                                cnt_ff <= ret_len;
                                busy_ff <= 1'b1;
                                st_ff <= ST_RD;
                            end else begin
                                done_ff <= 1'b1;
                            end
                        end
                    endcase
                end
            end
            ST_WR: begin
                // idx_ff is the offset below sp minus one
                stk_we_ff <= 1'b1;
                stk_addr_ff <= stack_pointer_ff - 8'h01 - {5'h00, idx_ff};
                stk_wdata_ff <= six_ff && (op_ff == `BCSC_OP_WIDE_ABSOLUTE_CALL || op_ff == `BCSC_OP_SHORT_FIXED_CALL) ?
                                nib_ff[idx_ff - 3'h1] : nib_ff[idx_ff];
                idx_ff <= idx_ff + 3'h1;
                cnt_ff <= cnt_ff - 3'h1;
                if (cnt_ff == 3'h1)
                    st_ff <= ST_FIN;
            end
            ST_RD: begin
                stk_addr_ff <= stack_pointer_ff + {5'h00, idx_ff};
                rd_pend_ff <= 1'b1;
                rd_idx_ff <= idx_ff;
                idx_ff <= idx_ff + 3'h1;
                cnt_ff <= cnt_ff - 3'h1;
                if (cnt_ff == 3'h1)
                    st_ff <= ST_FIN;
            end
            ST_FIN: begin
                if (!rd_pend_ff) begin
                    busy_ff <= 1'b0;
                    done_ff <= 1'b1;
                    st_ff <= ST_IDLE;
                    case (op_ff)
                        `BCSC_OP_WIDE_ABSOLUTE_CALL, `BCSC_OP_SHORT_FIXED_CALL: begin
                            stack_pointer_ff <= stack_pointer_ff - (six_ff ? 8'h06 : 8'h04);
                            pc_ff <= tgt_ff;
                            pc_load_ff <= 1'b1;
                        end
                        `BCSC_OP_PUSH, `BCSC_OP_PUSH_BS: begin
                            stack_pointer_ff <= stack_pointer_ff - 8'h02;
                        end
                        `BCSC_OP_POP: begin
                            reg_load_ff <= 1'b1;
                            reg_pair_ff <= pair_ff;
                            reg_lo_ff <= rd_ff[0];
                            reg_hi_ff <= rd_ff[1];
                            stack_pointer_ff <= stack_pointer_ff + 8'h02;
                        end
                        `BCSC_OP_POP_BS: begin
                            bs_load_ff <= 1'b1;
                            rbs_ff <= rd_ff[0][1:0];
                            mbs_ff <= rd_ff[1];
                            stack_pointer_ff <= stack_pointer_ff + 8'h02;
                        end
                        `BCSC_OP_RET, `BCSC_OP_RETURN_AND_SKIP, `BCSC_OP_INTERRUPT_RETURN: begin
                            pc_ff <= {rd_ff[0], rd_ff[3], rd_ff[2]};
                            pc_load_ff <= 1'b1;
                            psw_load_ff <= 1'b1;
                            if (op_ff == `BCSC_OP_INTERRUPT_RETURN) begin
                                psw_ff <= {rd_ff[5], rd_ff[4]};
                                stack_pointer_ff <= stack_pointer_ff + 8'h06;
                            end else begin
                                // only the bank enables change
                                psw_ff <= {(six_ff ? rd_ff[4][1:0] : rd_ff[1][3:2]), program_status_word[5:0]};
                                stack_pointer_ff <= stack_pointer_ff + (six_ff ? 8'h06 : 8'h04);
                            end
                            skip_ff <= (op_ff == `BCSC_OP_RETURN_AND_SKIP);
                        end
                        default: begin
                            done_ff <= 1'b1;
                        end
                    endcase
                end
            end
            default: st_ff <= ST_IDLE;
        endcase
    end
end

// ****************************************
// interrupt gating
// ****************************************
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        irq_s1_ff <= 7'h00;
        irq_s2_ff <= 7'h00;
        irq_accept_ff <= 7'h00;
    end else begin
        irq_s1_ff <= irq_req;
        irq_s2_ff <= irq_s1_ff;
        irq_accept_ff <= irq_s2_ff & source_interrupt_enable_ff & {7{master_interrupt_enable_ff}};
    end
end

endmodule // bcsc_core

// File: core/bcsc_defines.vh
`ifndef BCSC_DEFINES_VH
`define BCSC_DEFINES_VH
// operation codes on op_code
`define BCSC_OP_NOP 5'h00
`define BCSC_OP_PAGE_DE 5'h01
`define BCSC_OP_PAGE_XA 5'h02
`define BCSC_OP_FULL_D 5'h03
`define BCSC_OP_FULL_X 5'h04
`define BCSC_OP_WIDE_ABSOLUTE_CALL 5'h05
`define BCSC_OP_SHORT_FIXED_CALL 5'h06
`define BCSC_OP_RET 5'h07
`define BCSC_OP_RETURN_AND_SKIP 5'h08
`define BCSC_OP_INTERRUPT_RETURN 5'h09
`define BCSC_OP_PUSH 5'h0a
`define BCSC_OP_PUSH_BS 5'h0b
`define BCSC_OP_POP 5'h0c
`define BCSC_OP_POP_BS 5'h0d
`define BCSC_OP_EI 5'h0e
`define BCSC_OP_DI 5'h0f
`define BCSC_OP_EI_SRC 5'h10
`define BCSC_OP_DI_SRC 5'h11
// pair select
`define BCSC_RP_XA 2'h0
`define BCSC_RP_HL 2'h1
`define BCSC_RP_DE 2'h2
`define BCSC_RP_BC 2'h3
// number of interrupt sources and master enable position
`define BCSC_NSRC 7
`define BCSC_IME_BIT 3
// reset values, page-end offset and short call target mask
`define BCSC_SP_RST 8'h00
`define BCSC_PC_RST 12'h000
`define BCSC_PAGE_LAST 8'hfe
`define BCSC_FAR_MASK 12'h7ff
`endif

// File: tb/bcsc_stack_mem.sv
`timescale 1ns/1ps
module bcsc_stack_mem (
    // clock
    input wire mclk,
    // stack access
    input wire we,
    input wire [7:0] addr,
    input wire [3:0] wdata,
    output wire [3:0] rdata
);
reg [3:0] mem [0:255];
// read follows the registered address; the core captures it on the next edge
assign rdata = mem[addr];
always @(posedge mclk) begin
    if (we) begin
        mem[addr] <= wdata;
    end
end
endmodule // bcsc_stack_mem

// File: tb/bcsc_checker.sv
`timescale 1ns/1ps
`include "bcsc_defines.vh"
module bcsc_checker (
    // clock and reset
    input wire mclk, rst_n,
    // request
    input wire op_valid, six_nibble_frame_mode,
    input wire [4:0] op_code,
    input wire [11:0] op_pc, op_target,
    input wire [2:0] op_src,
    input wire [3:0] reg_a, reg_x, reg_c, reg_d, reg_e,
    input wire [7:0] program_status_word,
    // results
    input wire busy_ff, done_ff, pc_load_ff, skip_ff, psw_load_ff, master_interrupt_enable_ff,
    input wire [11:0] pc_ff,
    input wire [7:0] stack_pointer_ff, psw_ff,
    input wire [6:0] source_interrupt_enable_ff, irq_accept_ff
);
// ****************
// captured request
// ****************
reg [4:0] t_op_ff;
reg [11:0] t_pc_ff, t_tgt_ff;
reg [7:0] t_sp_ff;
reg t_six_ff;
reg [2:0] t_src_ff;
wire [3:0] t_page = t_pc_ff[11:8] + {3'h0, t_pc_ff[7:0] >= 8'hfe};
always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
        {t_op_ff, t_pc_ff, t_tgt_ff, t_sp_ff, t_six_ff, t_src_ff} <= 41'h0;
    end else if (op_valid && !busy_ff) begin
        {t_op_ff, t_pc_ff, t_tgt_ff, t_sp_ff, t_six_ff, t_src_ff} <=
            {op_code, op_pc, op_target, stack_pointer_ff, six_nibble_frame_mode, op_src};
    end
end
// **********
// assertions
// **********
default clocking cb @(posedge mclk); endclocking
default disable iff (!rst_n);
a_page_de_target: assert property (pc_load_ff && t_op_ff == `BCSC_OP_PAGE_DE |-> pc_ff == {t_page, reg_d, reg_e})
    else $error("page branch via d e wrong");
a_page_xa_target: assert property (pc_load_ff && t_op_ff == `BCSC_OP_PAGE_XA |-> pc_ff == {t_page, reg_x, reg_a})
    else $error("page branch via x a wrong");
a_full_target: assert property (pc_load_ff && (t_op_ff == `BCSC_OP_FULL_D || t_op_ff == `BCSC_OP_FULL_X) |->
    pc_ff == {reg_c, (t_op_ff == `BCSC_OP_FULL_D) ? {reg_d, reg_e} : {reg_x, reg_a}}) else $error("full branch wrong");
a_call_sp_step: assert property (done_ff && (t_op_ff == `BCSC_OP_WIDE_ABSOLUTE_CALL || t_op_ff == `BCSC_OP_SHORT_FIXED_CALL) |->
    stack_pointer_ff == t_sp_ff - (t_six_ff ? 8'h06 : 8'h04)) else $error("call stack step wrong");
a_short_call_pc: assert property (pc_load_ff && t_op_ff == `BCSC_OP_SHORT_FIXED_CALL |-> pc_ff == {1'b0, t_tgt_ff[10:0]})
    else $error("short call target wrong");
a_pair_sp_step: assert property (done_ff && t_op_ff >= `BCSC_OP_PUSH && t_op_ff <= `BCSC_OP_POP_BS |->
    stack_pointer_ff == ((t_op_ff < `BCSC_OP_POP) ? t_sp_ff - 8'h02 : t_sp_ff + 8'h02)) else $error("push pop step wrong");
a_return_sp_step: assert property (done_ff && t_op_ff >= `BCSC_OP_RET && t_op_ff <= `BCSC_OP_INTERRUPT_RETURN |->
    stack_pointer_ff == t_sp_ff + ((t_six_ff || t_op_ff == `BCSC_OP_INTERRUPT_RETURN) ? 8'h06 : 8'h04)) else $error("return step wrong");
a_skip_on_return_and_skip: assert property (done_ff |-> skip_ff == (t_op_ff == `BCSC_OP_RETURN_AND_SKIP))
    else $error("skip pulse wrong");
a_ret_psw_keep: assert property (psw_load_ff && (t_op_ff == `BCSC_OP_RET || t_op_ff == `BCSC_OP_RETURN_AND_SKIP) |->
    psw_ff[5:0] == program_status_word[5:0]) else $error("return touched other status flags");
a_master_enable: assert property (done_ff && (t_op_ff == `BCSC_OP_EI || t_op_ff == `BCSC_OP_DI) |->
    master_interrupt_enable_ff == (t_op_ff == `BCSC_OP_EI)) else $error("master enable wrong");
a_source_enable: assert property (done_ff && (t_op_ff == `BCSC_OP_EI_SRC || t_op_ff == `BCSC_OP_DI_SRC) && t_src_ff != 3'h7
    |-> source_interrupt_enable_ff[t_src_ff] == (t_op_ff == `BCSC_OP_EI_SRC)) else $error("source enable wrong");
a_accept_gate: assert property (irq_accept_ff != 7'h00 |-> ($past(master_interrupt_enable_ff) || master_interrupt_enable_ff)
    && (irq_accept_ff & ~(source_interrupt_enable_ff | $past(source_interrupt_enable_ff))) == 7'h00)
    else $error("interrupt accepted while disabled");
endmodule // bcsc_checker
bind bcsc_core bcsc_checker i_bcsc_checker (.mclk, .rst_n, .op_valid, .six_nibble_frame_mode, .op_code, .op_pc,
    .op_target, .op_src, .reg_a, .reg_x, .reg_c, .reg_d, .reg_e, .program_status_word, .busy_ff, .done_ff,
    .pc_load_ff, .skip_ff, .psw_load_ff, .master_interrupt_enable_ff, .pc_ff, .stack_pointer_ff, .psw_ff,
    .source_interrupt_enable_ff, .irq_accept_ff);

// File: tb/branch_call_stack_control_tb.sv
`timescale 1ns/1ps
`include "bcsc_defines.vh"
module branch_call_stack_control_tb;
localparam [15:0] hi_tab = 16'h7532;
localparam [15:0] lo_tab = 16'h9641;
localparam [47:0] pcs = 48'hffe_2ff_2fe_2fd;
localparam [15:0] call4 = 16'ha385;
localparam [19:0] call6 = 20'h1d701;
localparam [23:0] reti6 = 24'hc5be03;
reg mclk, rst_n, op_valid, six_nibble_frame_mode;
reg [4:0] op_code;
reg [11:0] op_pc, op_target, t;
reg [1:0] op_pair, register_bank_select;
reg [2:0] op_src;
reg [3:0] reg_a, reg_x, reg_b, reg_c, reg_d, reg_e, reg_h, reg_l, memory_bank_select;
reg [7:0] program_status_word, sp;
reg [6:0] irq_req;
wire stk_we_ff, busy_ff, done_ff, pc_load_ff, skip_ff, reg_load_ff, bs_load_ff, psw_load_ff, master_interrupt_enable_ff;
wire [7:0] stk_addr_ff, stack_pointer_ff, psw_ff;
wire [3:0] stk_wdata_ff, stk_rdata, reg_hi_ff, reg_lo_ff, mbs_ff;
wire [11:0] pc_ff;
wire [1:0] reg_pair_ff, rbs_ff;
wire [6:0] source_interrupt_enable_ff, irq_accept_ff;
integer miscompares, checks_done, cycles, i;
bcsc_core i_bcsc_core (.mclk, .rst_n, .op_valid, .op_code, .op_pc, .op_target, .op_pair, .op_src,
    .six_nibble_frame_mode, .reg_a, .reg_x, .reg_b, .reg_c, .reg_d, .reg_e, .reg_h, .reg_l, .memory_bank_select,
    .register_bank_select, .program_status_word, .irq_req, .stk_we_ff, .stk_addr_ff, .stk_wdata_ff, .stk_rdata,
    .busy_ff, .done_ff, .pc_load_ff, .pc_ff, .skip_ff, .stack_pointer_ff, .reg_load_ff, .reg_pair_ff, .reg_hi_ff,
    .reg_lo_ff, .bs_load_ff, .mbs_ff, .rbs_ff, .psw_load_ff, .psw_ff, .master_interrupt_enable_ff,
    .source_interrupt_enable_ff, .irq_accept_ff);
bcsc_stack_mem i_bcsc_stack_mem (.mclk, .we(stk_we_ff), .addr(stk_addr_ff), .wdata(stk_wdata_ff), .rdata(stk_rdata));
// *****************
// checks and tasks
// *****************
task check(input [31:0] seen, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    end
endtask
task report_and_stop;
    begin
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    end
endtask
// issue one operation and wait for its completion pulse
task run(input [4:0] code);
    integer n;
    begin
        op_code <= code;
        op_valid <= 1'b1;
        @(posedge mclk);
        op_valid <= 1'b0;
        n = 0;
        @(posedge mclk);
        while (done_ff !== 1'b1 && n < 12) begin
            @(posedge mclk);
            n = n + 1;
        end
        check(done_ff, 1'b1);
    end
endtask
initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
end
always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles > 3000) begin
        miscompares = miscompares + 1;
        report_and_stop;
    end
end
// **********
// sequence
// **********
initial begin
    {rst_n, op_valid, six_nibble_frame_mode, op_code, op_pc, op_target, op_pair, op_src, irq_req} = 0;
    {reg_a, reg_x, reg_h, reg_l, reg_d, reg_e, reg_b, reg_c} = 32'h1234_5679;
    memory_bank_select = 4'hc;
    register_bank_select = 2'h2;
    program_status_word = 8'h85;
    {miscompares, checks_done, cycles, sp} = 0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (i = 0; i < 4; i = i + 1) begin
        op_pair <= i[1:0];
        run(`BCSC_OP_PUSH);
        sp = sp - 8'h02;
        check(stack_pointer_ff, sp);
        check(i_bcsc_stack_mem.mem[sp + 8'h01], hi_tab[4*i +: 4]);
        check(i_bcsc_stack_mem.mem[sp], lo_tab[4*i +: 4]);
    end
    run(`BCSC_OP_PUSH_BS);
    sp = sp - 8'h02;
    check(i_bcsc_stack_mem.mem[sp + 8'h01], 4'hc);
    check(i_bcsc_stack_mem.mem[sp], 4'h2);
    run(`BCSC_OP_POP_BS);
    sp = sp + 8'h02;
    check({bs_load_ff, mbs_ff, rbs_ff, stack_pointer_ff}, {1'b1, 4'hc, 2'h2, sp});
    for (i = 3; i >= 0; i = i - 1) begin
        op_pair <= i[1:0];
        run(`BCSC_OP_POP);
        sp = sp + 8'h02;
        check({reg_load_ff, reg_pair_ff, reg_hi_ff, reg_lo_ff}, {1'b1, i[1:0], hi_tab[4*i +: 4], lo_tab[4*i +: 4]});
        check(stack_pointer_ff, sp);
    end
    reg_b <= 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
        t = pcs[12*i +: 12];
        op_pc <= t;
        run(`BCSC_OP_PAGE_DE);
        check(pc_ff, {t[11:8] + {3'h0, t[7:0] >= 8'hfe}, 8'h56});
        run(`BCSC_OP_PAGE_XA);
        check(pc_ff, {t[11:8] + {3'h0, t[7:0] >= 8'hfe}, 8'h21});
    end
    run(`BCSC_OP_FULL_D);
    check(pc_ff, 12'h956);
    run(`BCSC_OP_FULL_X);
    check(pc_ff, 12'h921);
    op_pc <= 12'h5a3;
    op_target <= 12'habc;
    run(`BCSC_OP_WIDE_ABSOLUTE_CALL);
    check({pc_ff, stack_pointer_ff}, 20'habcfc);
    for (i = 0; i < 4; i = i + 1) check(i_bcsc_stack_mem.mem[8'hfc + i[7:0]], call4[4*i +: 4]);
    program_status_word <= 8'h45;
    run(`BCSC_OP_RET);
    check({pc_ff, psw_ff, stack_pointer_ff, skip_ff}, {20'h5a385, 8'h00, 1'b0});
    six_nibble_frame_mode <= 1'b1;
    program_status_word <= 8'h40;
    op_pc <= 12'h1d7;
    op_target <= 12'hfed;
    run(`BCSC_OP_SHORT_FIXED_CALL);
    check({pc_ff, stack_pointer_ff}, 20'h7edfa);
    for (i = 0; i < 5; i = i + 1) check(i_bcsc_stack_mem.mem[8'hfa + i[7:0]], call6[4*i +: 4]);
    check(i_bcsc_stack_mem.mem[8'hff], 4'ha);
    program_status_word <= 8'h8a;
    run(`BCSC_OP_RETURN_AND_SKIP);
    check({pc_ff, psw_ff, stack_pointer_ff, skip_ff}, {20'h1d74a, 8'h00, 1'b1});
    six_nibble_frame_mode <= 1'b0;
    for (i = 0; i < 6; i = i + 1) i_bcsc_stack_mem.mem[i] = reti6[4*i +: 4];
    run(`BCSC_OP_INTERRUPT_RETURN);
    check({psw_load_ff, pc_ff, psw_ff, stack_pointer_ff}, {1'b1, 20'h3bec5, 8'h06});
    irq_req <= 7'h7f;
    run(`BCSC_OP_EI);
    check(master_interrupt_enable_ff, 1'b1);
    for (i = 0; i < 7; i = i + 1) begin
        op_src <= i[2:0];
        run(`BCSC_OP_EI_SRC);
        check(source_interrupt_enable_ff[i], 1'b1);
    end
    repeat (4) @(posedge mclk);
    check(irq_accept_ff, 7'h7f);
    op_src <= 3'h2;
    run(`BCSC_OP_DI_SRC);
    op_src <= 3'h7;
    run(`BCSC_OP_DI_SRC);
    repeat (4) @(posedge mclk);
    check({source_interrupt_enable_ff, irq_accept_ff}, 14'h3dfb);
    run(`BCSC_OP_DI);
    repeat (4) @(posedge mclk);
    check({master_interrupt_enable_ff, irq_accept_ff}, 8'h00);
    report_and_stop;
end
endmodule // branch_call_stack_control_tb
